// ---- logic/fmnf_pkg.sv ----
// Purpose: Shared constants and types of the field memory noise filter.
// Assumes: One core clock samples every pin of the video controller.
// Notes: Sizes follow the array organisation and the filter pipeline.
package fmnf_pkg;
   // ==========================================================================
   // Sizes
   localparam int unsigned SMP_W = 12;
   localparam int unsigned WORDS = 16;
   localparam int unsigned ROWS = 212;
   localparam int unsigned COLS = 64;
   localparam int unsigned LUMA_W = 8;
   localparam int unsigned CHROMA_W = 4;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned COL_W = 6;
   localparam int unsigned MEM_AW = 14;
   localparam int unsigned FILT_LAT = 8;
   localparam int unsigned WQ_DEPTH = 8;
   localparam int unsigned K_W = 7;
   localparam int unsigned K_LEVELS = 13;
   // ==========================================================================
   // Field positions and fixed values
   localparam int unsigned MODE_HI_POS = 7;
   localparam int unsigned MODE_LO_POS = 6;
   localparam logic [K_W-1:0] K_ONE = 7'h40;
   localparam logic [3:0] K_IDX_MAX = 4'hC;
   localparam logic [ADDR_W-1:0] REFRESH_LAST = 8'hD3;
   localparam logic [8:0] IDX_SAT = 9'h00C;
   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      OP_READ_A = 2'h0,
      OP_READ_B = 2'h1,
      OP_WRITE = 2'h2,
      OP_REFRESH = 2'h3
   } fmnf_op_t;
   typedef enum logic [2:0] {
      CLS_LOW = 3'h0,
      CLS_LOWMID = 3'h1,
      CLS_MIDHIGH = 3'h2,
      CLS_HIGH = 3'h3,
      CLS_OFF = 3'h4
   } fmnf_class_t;
   typedef logic [SMP_W-1:0] fmnf_word_t;
   typedef fmnf_word_t [WORDS-1:0] fmnf_group_t;
   typedef struct packed {
      logic port_clock;
      logic addr_shift_clock;
      logic row_addr_serial;
      logic col_addr_serial;
      logic row_xfer_n;
      logic write_xfer_n;
      logic loop_read_xfer_n;
      logic format_select;
      logic [2:0] strength;
      logic chroma_delay_oe_n;
      logic [CHROMA_W-1:0] chroma_delay_in;
      fmnf_word_t sample_in;
   } fmnf_pins_t;
   typedef struct packed {
      logic [MEM_AW-1:0] addr;
      fmnf_group_t data;
   } fmnf_wreq_t;
   localparam fmnf_pins_t PINS_RST = '{row_xfer_n: 1'b1, write_xfer_n: 1'b1, loop_read_xfer_n: 1'b1,
      chroma_delay_oe_n: 1'b1, default: '0};
endpackage

// ---- logic/fmnf_top.sv ----
// Purpose: Input side of a serial field memory with a recursive noise filter.
// Assumes: All controller pins are asynchronous and pass two flip-flops first.
// Function
// - Coefficient one passes samples unchanged.
// - Output mixes input and previous field by coefficient.
// - Per-pixel coefficient from filtered absolute field difference.
// - Motion detection looks at luminance only.
// - Strength pins choose mapping or disable filtering.
// - Format pin: full filtering or luminance only.
// - Array is 212 rows by 64 columns.
// - Every transfer moves sixteen words together.
// - Input shift register feeds its latch; loop latch feeds loop shift register; port A has a latch only.
// - Eight-bit serial row and column with mode bits.
// - Loop read port only feeds the filter.
// - Filter latency is eight port clocks.
// - Input shift register takes one sample per edge.
// - Only the last sixteen samples are kept.
// - Delay line outputs lag inputs eight port clocks.
// - Delay line output enable is active low.
// - Write strobe fall copies shift register to latch.
// - Row strobe rise writes latch for mode two.
// - Mode bits choose reads, write or refresh.
// - Addresses shift LSB first, latch on strobe fall.
`timescale 1ns/1ps
`default_nettype none

// =============================================================================
// Write request queue
module fmnf_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_q, rd_q;
   logic [PW:0] cnt_q;
   logic push, pop;

   assign o_in_ready = cnt_q != (PW+1)'(DEPTH);
   assign o_out_valid = cnt_q != '0;
   assign o_out_data = mem[rd_q];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// =============================================================================
// Field memory with noise filter
module fmnf_top import fmnf_pkg::*; #(
   parameter logic [K_LEVELS-1:0][K_W-1:0] K_TABLE = {7'h40, 7'h3C, 7'h38, 7'h34, 7'h30, 7'h2C, 7'h28,
      7'h24, 7'h20, 7'h1C, 7'h18, 7'h14, 7'h10},
   parameter logic [3:0][1:0] CLASS_SHIFT = {2'h3, 2'h2, 2'h1, 2'h0}
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_port_clock,
   input wire logic i_addr_shift_clock,
   input wire logic i_row_addr_serial,
   input wire logic i_col_addr_serial,
   input wire logic i_row_xfer_n,
   input wire logic i_write_xfer_n,
   input wire logic i_loop_read_xfer_n,
   input wire logic i_format_select,
   input wire logic i_strength_sel_hi,
   input wire logic i_strength_sel_mid,
   input wire logic i_strength_sel_lo,
   input wire logic i_chroma_delay_oe_n,
   input wire logic [CHROMA_W-1:0] i_chroma_delay_in,
   input wire logic [SMP_W-1:0] i_sample_in,
   output logic [CHROMA_W-1:0] o_chroma_delay_out,
   output logic o_chroma_delay_oe,
   output fmnf_group_t o_latch_a,
   output logic [ADDR_W-1:0] o_refresh_row,
   output logic o_write_ready
);
   function automatic logic [LUMA_W-1:0] mix(input logic [LUMA_W-1:0] a, input logic [LUMA_W-1:0] b,
      input logic [K_W-1:0] k);
      logic [15:0] acc;
      acc = 16'(k) * 16'(a) + 16'(K_ONE - k) * 16'(b) + 16'h0020;
      return acc[13:6];
   endfunction

   fmnf_pins_t pin_meta_q, pin_q, pin_prev_q;
   fmnf_group_t mem [ROWS*COLS];
   fmnf_group_t shc_q, latch_c_q, latch_b_q, shb_q, latch_a_q;
   fmnf_word_t pipe_q [FILT_LAT];
   logic [CHROMA_W-1:0] dl_q [FILT_LAT];
   logic [CHROMA_W-1:0] dl_out_q;
   logic [3:0] shb_idx_q;
   logic [ADDR_W-1:0] row_sr_q, col_sr_q, row_q, col_q, refresh_row_q;
   logic signed [8:0] diff_q;
   logic tick, sclk_rise, row_fall, row_rise, wr_fall, loop_fall;
   logic [MEM_AW-1:0] sr_addr, lat_addr;
   logic sr_row_ok, lat_row_ok;
   fmnf_op_t sr_op, lat_op;
   fmnf_class_t cls;
   fmnf_word_t prev_word, filt_word;
   logic signed [8:0] diff;
   logic signed [9:0] lp_sum;
   logic [8:0] mag, shifted;
   logic [3:0] k_idx;
   logic [K_W-1:0] coef;
   logic [LUMA_W-1:0] luma_mix, chroma_mix;
   fmnf_wreq_t wq_out;
   logic wq_push, wq_valid, wq_pop;

   // ==========================================================================
   // Pin synchronisers and edge finders
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_meta_q <= PINS_RST;
         pin_q <= PINS_RST;
         pin_prev_q <= PINS_RST;
      end else begin
         pin_meta_q <= '{i_port_clock, i_addr_shift_clock, i_row_addr_serial, i_col_addr_serial, i_row_xfer_n,
            i_write_xfer_n, i_loop_read_xfer_n, i_format_select,
            {i_strength_sel_hi, i_strength_sel_mid, i_strength_sel_lo}, i_chroma_delay_oe_n,
            i_chroma_delay_in, i_sample_in};
         pin_q <= pin_meta_q;
         pin_prev_q <= pin_q;
      end
   end

   assign tick = pin_q.port_clock && !pin_prev_q.port_clock;
   assign sclk_rise = pin_q.addr_shift_clock && !pin_prev_q.addr_shift_clock;
   assign row_fall = !pin_q.row_xfer_n && pin_prev_q.row_xfer_n;
   assign row_rise = pin_q.row_xfer_n && !pin_prev_q.row_xfer_n;
   assign wr_fall = !pin_q.write_xfer_n && pin_prev_q.write_xfer_n;
   assign loop_fall = !pin_q.loop_read_xfer_n && pin_prev_q.loop_read_xfer_n;

   // ==========================================================================
   // Motion detector and coefficient choice
   always_comb begin
      case (pin_q.strength)
         3'h0, 3'h4: cls = CLS_LOW;
         3'h1, 3'h5: cls = CLS_LOWMID;
         3'h2: cls = CLS_MIDHIGH;
         3'h6: cls = CLS_HIGH;
         default: cls = CLS_OFF;
      endcase
   end

   assign prev_word = shb_q[shb_idx_q];
   assign diff = $signed({1'b0, pin_q.sample_in[SMP_W-1:CHROMA_W]})
      - $signed({1'b0, prev_word[SMP_W-1:CHROMA_W]});
   assign lp_sum = 10'(diff) + 10'(diff_q);
   assign mag = lp_sum[9] ? 9'(-lp_sum[9:1]) : lp_sum[9:1];

   always_comb begin
      shifted = mag >> ((cls == CLS_OFF) ? 2'h0 : CLASS_SHIFT[cls[1:0]]);
      k_idx = (shifted > IDX_SAT) ? K_IDX_MAX : shifted[3:0];
      coef = (cls == CLS_OFF) ? K_ONE : K_TABLE[k_idx];
   end

   // ==========================================================================
   // Recursive mixer
   assign luma_mix = mix(pin_q.sample_in[SMP_W-1:CHROMA_W], prev_word[SMP_W-1:CHROMA_W], coef);
   assign chroma_mix = mix({4'h0, pin_q.sample_in[CHROMA_W-1:0]}, {4'h0, prev_word[CHROMA_W-1:0]}, coef);
   assign filt_word = {luma_mix,
      pin_q.format_select ? pin_q.sample_in[CHROMA_W-1:0] : chroma_mix[CHROMA_W-1:0]};

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         diff_q <= '0;
      end else if (tick) begin
         diff_q <= diff;
      end
   end

   // Filter pipeline and chroma delay line; a sample taken at one port edge
   // reaches the shift register or delay line output eight port edges later.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < FILT_LAT; i++) begin
            pipe_q[i] <= '0;
            dl_q[i] <= '0;
         end
         dl_out_q <= '0;
      end else if (tick) begin
         pipe_q[0] <= filt_word;
         dl_q[0] <= pin_q.chroma_delay_in;
         for (int i = 1; i < FILT_LAT; i++) begin
            pipe_q[i] <= pipe_q[i-1];
            dl_q[i] <= dl_q[i-1];
         end
         dl_out_q <= dl_q[FILT_LAT-1];
      end
   end

   assign o_chroma_delay_out = dl_out_q;
   assign o_chroma_delay_oe = !pin_q.chroma_delay_oe_n;

   // ==========================================================================
   // Shift registers and latches
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shc_q <= '0;
      end else if (tick) begin
         shc_q <= {pipe_q[FILT_LAT-1], shc_q[WORDS-1:1]};
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_c_q <= '0;
      end else if (wr_fall) begin
         latch_c_q <= shc_q;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shb_q <= '0;
         shb_idx_q <= '0;
      end else if (loop_fall) begin
         shb_q <= latch_b_q;
         shb_idx_q <= '0;
      end else if (tick) begin
         shb_idx_q <= shb_idx_q + 4'h1;
      end
   end

   // ==========================================================================
   // Serial addressing
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         row_sr_q <= '0;
         col_sr_q <= '0;
      end else if (sclk_rise) begin
         row_sr_q <= {pin_q.row_addr_serial, row_sr_q[ADDR_W-1:1]};
         col_sr_q <= {pin_q.col_addr_serial, col_sr_q[ADDR_W-1:1]};
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         row_q <= '0;
         col_q <= '0;
      end else if (row_fall) begin
         row_q <= row_sr_q;
         col_q <= col_sr_q;
      end
   end

   assign sr_op = fmnf_op_t'({col_sr_q[MODE_HI_POS], col_sr_q[MODE_LO_POS]});
   assign lat_op = fmnf_op_t'({col_q[MODE_HI_POS], col_q[MODE_LO_POS]});
   assign sr_row_ok = row_sr_q < ADDR_W'(ROWS);
   assign lat_row_ok = row_q < ADDR_W'(ROWS);
   assign sr_addr = MEM_AW'(row_sr_q) * MEM_AW'(COLS) + MEM_AW'(col_sr_q[COL_W-1:0]);
   assign lat_addr = MEM_AW'(row_q) * MEM_AW'(COLS) + MEM_AW'(col_q[COL_W-1:0]);

   // ==========================================================================
   // Array transfers
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_a_q <= '0;
         latch_b_q <= '0;
         refresh_row_q <= '0;
      end else if (row_fall) begin
         case (sr_op)
            OP_READ_A: begin
               latch_a_q <= sr_row_ok ? mem[sr_addr] : '0;
            end
            OP_READ_B: begin
               latch_b_q <= sr_row_ok ? mem[sr_addr] : '0;
            end
            OP_REFRESH: begin
               refresh_row_q <= (refresh_row_q == REFRESH_LAST) ? '0 : refresh_row_q + 8'h01;
            end
            default: latch_a_q <= latch_a_q;
         endcase
      end
   end

   assign o_latch_a = latch_a_q;
   assign o_refresh_row = refresh_row_q;

   // The array has one port, so queued writes yield to a read in the same cycle.
   assign wq_push = row_rise && lat_op == OP_WRITE && lat_row_ok;
   assign wq_pop = !row_fall;

   fmnf_fifo #(.W($bits(fmnf_wreq_t)), .DEPTH(WQ_DEPTH)) u_wq (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(wq_push),
      .o_in_ready(o_write_ready),
      .i_in_data({lat_addr, latch_c_q}),
      .o_out_valid(wq_valid),
      .i_out_ready(wq_pop),
      .o_out_data(wq_out)
   );

   always_ff @(posedge i_core_clk) begin
      if (wq_valid && wq_pop) begin
         mem[wq_out.addr] <= wq_out.data;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_tick;
      tick;
   endsequence
   sequence s_unity_tick;
      tick && coef == K_ONE && !pin_q.format_select;
   endsequence

   a_unity_pass: assert property (s_unity_tick |=> pipe_q[0] == $past(pin_q.sample_in))
      else $error("unity coefficient changed a sample");
   a_mix_between: assert property (s_tick |=> pipe_q[0][11:4] == $past(luma_mix)
      && ((pipe_q[0][11:4] >= $past(pin_q.sample_in[11:4]) && pipe_q[0][11:4] <= $past(prev_word[11:4]))
      || (pipe_q[0][11:4] <= $past(pin_q.sample_in[11:4]) && pipe_q[0][11:4] >= $past(prev_word[11:4]))))
      else $error("mixed luma outside its inputs");
   a_coef_range: assert property (coef >= 7'h10 && coef <= K_ONE)
      else $error("coefficient out of range");
   a_class_off: assert property (pin_q.strength[1:0] == 2'h3 |-> coef == K_ONE)
      else $error("filter not off");
   a_chroma_bypass: assert property (s_tick ##0 pin_q.format_select |=>
      pipe_q[0][3:0] == $past(pin_q.sample_in[3:0])) else $error("chroma filtered in luma-only mode");
   a_pipe_walk: assert property (s_tick ##1 (!tick)[*1] |-> shc_q[WORDS-1] == $past(pipe_q[FILT_LAT-1], 2))
      else $error("shift register input not from last stage");
   a_delay_line: assert property (s_tick |=> dl_out_q == $past(dl_q[FILT_LAT-1]))
      else $error("delay line output wrong");
   a_oe_follow: assert property (o_chroma_delay_oe == !pin_q.chroma_delay_oe_n)
      else $error("delay line enable wrong");
   a_latch_copy: assert property (wr_fall |=> latch_c_q == $past(shc_q))
      else $error("input latch not loaded");
   a_addr_latch: assert property (row_fall |=> row_q == $past(row_sr_q) && col_q == $past(col_sr_q))
      else $error("address not latched");
   a_write_queued: assert property (wq_push && o_write_ready |=> wq_valid)
      else $error("write transfer lost");
endmodule

`default_nettype wire

// ---- verification/fmnf_ctrl_model.sv ----
// Purpose: Behavioural video controller that drives the field memory pins.
// Assumes: Port and address clocks stand still between frames.
// Notes: Tasks are called by the testbench; serial lines show inverted data when idle.
`timescale 1ns/1ps
`default_nettype none

// =============================================================================
// Controller model
module fmnf_ctrl_model import fmnf_pkg::*; (
   output logic o_port_clock,
   output logic o_addr_shift_clock,
   output logic o_row_addr_serial,
   output logic o_col_addr_serial,
   output logic o_row_xfer_n,
   output logic o_write_xfer_n,
   output logic o_loop_read_xfer_n,
   output logic [CHROMA_W-1:0] o_chroma_delay_in,
   output logic [SMP_W-1:0] o_sample_in
);
   initial begin
      o_port_clock = 1'b0;
      o_addr_shift_clock = 1'b0;
      o_row_addr_serial = 1'b0;
      o_col_addr_serial = 1'b0;
      o_row_xfer_n = 1'b1;
      o_write_xfer_n = 1'b1;
      o_loop_read_xfer_n = 1'b1;
      o_chroma_delay_in = 4'h0;
      o_sample_in = 12'h000;
   end

   // One 48 ns port clock period; data settles half a period before the rise.
   task automatic tick(input logic [SMP_W-1:0] smp, input logic [CHROMA_W-1:0] dly);
      o_sample_in = smp;
      o_chroma_delay_in = dly;
      #24 o_port_clock = 1'b1;
      #24 o_port_clock = 1'b0;
   endtask

   // Eight address bits least significant first, then a full row strobe.
   task automatic addr_cycle(input logic [ADDR_W-1:0] row, input logic [ADDR_W-1:0] col);
      for (int i = 0; i < int'(ADDR_W); i++) begin
         o_row_addr_serial = row[i];
         o_col_addr_serial = col[i];
         #20 o_addr_shift_clock = 1'b1;
         #20 o_addr_shift_clock = 1'b0;
      end
      o_row_addr_serial = ~row[ADDR_W-1];
      o_col_addr_serial = ~col[ADDR_W-1];
      #40 o_row_xfer_n = 1'b0;
      #80 o_row_xfer_n = 1'b1;
      #80;
   endtask

   // The write strobe is kept well clear of any row strobe edge.
   task automatic pulse_wt();
      #40 o_write_xfer_n = 1'b0;
      #40 o_write_xfer_n = 1'b1;
      #40;
   endtask

   task automatic pulse_rb();
      #40 o_loop_read_xfer_n = 1'b0;
      #40 o_loop_read_xfer_n = 1'b1;
      #40;
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_fmnf_top.sv ----
// Purpose: Self-checking testbench of the field memory noise filter.
// Assumes: Unwritten loop storage resets to zero.
// Notes: Groups are written and read back through latch A to observe the filter.
`timescale 1ns/1ps
`default_nettype none

// =============================================================================
// Testbench top
module tb_fmnf_top import fmnf_pkg::*; ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fmt = 1'b0;
   logic [2:0] str = 3'h3;
   logic oe_n = 1'b1;
   logic port_clock, addr_clock, row_ser, col_ser, row_xfer_n, write_xfer_n, loop_xfer_n;
   logic [CHROMA_W-1:0] dly_in;
   logic [CHROMA_W-1:0] dly_out;
   logic [SMP_W-1:0] sample;
   logic dly_oe;
   logic wr_rdy;
   logic [ADDR_W-1:0] rrow;
   fmnf_group_t latch_a;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   fmnf_ctrl_model pt (
      .o_port_clock(port_clock),
      .o_addr_shift_clock(addr_clock),
      .o_row_addr_serial(row_ser),
      .o_col_addr_serial(col_ser),
      .o_row_xfer_n(row_xfer_n),
      .o_write_xfer_n(write_xfer_n),
      .o_loop_read_xfer_n(loop_xfer_n),
      .o_chroma_delay_in(dly_in),
      .o_sample_in(sample)
   );

   fmnf_top uut (
      .i_core_clk(clk),
      .i_sys_rst(rst),
      .i_port_clock(port_clock),
      .i_addr_shift_clock(addr_clock),
      .i_row_addr_serial(row_ser),
      .i_col_addr_serial(col_ser),
      .i_row_xfer_n(row_xfer_n),
      .i_write_xfer_n(write_xfer_n),
      .i_loop_read_xfer_n(loop_xfer_n),
      .i_format_select(fmt),
      .i_strength_sel_hi(str[2]),
      .i_strength_sel_mid(str[1]),
      .i_strength_sel_lo(str[0]),
      .i_chroma_delay_oe_n(oe_n),
      .i_chroma_delay_in(dly_in),
      .i_sample_in(sample),
      .o_chroma_delay_out(dly_out),
      .o_chroma_delay_oe(dly_oe),
      .o_latch_a(latch_a),
      .o_refresh_row(rrow),
      .o_write_ready(wr_rdy)
   );

   // ==========================================================================
   // Reporting
   task automatic stop_test();
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [191:0] seen, input logic [191:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   // ==========================================================================
   // Stimulus helpers
   function automatic fmnf_group_t grp(input fmnf_word_t base, input fmnf_word_t step, input int first);
      fmnf_group_t g;
      for (int i = 0; i < int'(WORDS); i++) begin
         g[i] = base + fmnf_word_t'(first + i) * step;
      end
      return g;
   endfunction

   // Feeds a ramp of samples; in 4:2:2 mode the delay line output is checked each tick from the ninth on.
   task automatic feed(input int cnt, input fmnf_word_t base, input fmnf_word_t step);
      for (int n = 0; n < cnt; n++) begin
         pt.tick(base + fmnf_word_t'(n) * step, fmt ? 4'(n) ^ 4'h9 : 4'h0);
         if (fmt && n >= 8) begin
            chk("delay_out", 192'(dly_out), 192'(4'(n - 8) ^ 4'h9));
         end
      end
   endtask

   task automatic put_row(input logic [ADDR_W-1:0] row);
      pt.pulse_wt();
      pt.addr_cycle(row, {OP_WRITE, 6'h15});
   endtask

   task automatic get_row(input logic [ADDR_W-1:0] row, input fmnf_op_t op);
      pt.addr_cycle(row, {op, 6'h15});
   endtask

   // Previous field holds 0xA5C; input 0xA53 has equal luma, so motion is zero,
   // while input 0xA93 moves luma by four and lets the class shift the coefficient.
   task automatic nr_case(input logic [2:0] s, input logic f, input fmnf_word_t smp, input fmnf_word_t exp);
      @(negedge clk);
      str = s;
      fmt = f;
      oe_n = ~f;
      get_row(8'h31, OP_READ_B);
      pt.pulse_rb();
      feed(25, smp, 12'h000);
      chk("delay_oe", 192'(dly_oe), 192'(f));
      put_row(8'h32);
      get_row(8'h32, OP_READ_A);
      chk("filtered", latch_a, grp(exp, 12'h000, 0));
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("write_ready", 192'(wr_rdy), 192'h1);
      chk("delay_oe", 192'(dly_oe), 192'h0);
      chk("refresh_row", 192'(rrow), 192'h0);
      feed(28, 12'h005, 12'h025);
      put_row(8'h2A);
      put_row(8'hD3);
      get_row(8'h2A, OP_READ_A);
      chk("group_a", latch_a, grp(12'h005, 12'h025, 4));
      get_row(8'hD4, OP_READ_A);
      chk("row_out_of_range", latch_a, 192'h0);
      get_row(8'hD3, OP_READ_A);
      chk("group_last_row", latch_a, grp(12'h005, 12'h025, 4));
      get_row(8'h00, OP_REFRESH);
      chk("refresh_row", 192'(rrow), 192'h1);
      get_row(8'h00, OP_REFRESH);
      chk("refresh_row", 192'(rrow), 192'h2);
      feed(24, 12'hA5C, 12'h000);
      put_row(8'h31);
      for (int c = 0; c < 8; c++) begin
         nr_case(3'(c), 1'b0, 12'hA53, (c[1:0] == 2'h3) ? 12'hA53 : 12'hA5A);
      end
      nr_case(3'h0, 1'b0, 12'hA93, 12'hA78);
      nr_case(3'h1, 1'b0, 12'hA93, 12'hA79);
      nr_case(3'h2, 1'b0, 12'hA93, 12'hA69);
      nr_case(3'h6, 1'b0, 12'hA93, 12'hA6A);
      nr_case(3'h0, 1'b1, 12'hA53, 12'hA53);
      stop_test();
   end
endmodule
`default_nettype wire
